// ==== ubr_pkg.sv ====
// constants, types and helpers for the uart data buffer registers
// What this block does
// - receive registers show oldest of two frames
// - nine-bit low-first pops on high read
// - receive complete set while queue holds data
// - overflow on start with queue and frame register full
// - reading receive data clears overflow
// - error flags stay clear in spi host mode
// - frame error follows first stop bit
// - parity error when enabled check fails
// - high byte bit zero holds ninth bit
// - lin mode bit zero marks response data
// - transmit data goes buffer, shifter, pin
// - nine-bit low-first commits on high write
package ubr_pkg;
    localparam logic [3:0] ADDR_RX_LOW = 4'h0;
    localparam logic [3:0] ADDR_RX_HIGH = 4'h1;
    localparam logic [3:0] ADDR_TX_LOW = 4'h2;
    localparam logic [3:0] ADDR_TX_HIGH = 4'h3;
    localparam logic [3:0] ADDR_CFG = 4'h4;
    localparam logic [3:0] ADDR_BAUD = 4'h5;
    localparam logic [3:0] ADDR_IRQ_STAT = 4'h6;
    localparam logic [3:0] ADDR_IRQ_MASK = 4'h7;
    localparam logic [2:0] CHARACTER_SIZE_9L = 3'h6;
    localparam logic [2:0] CHARACTER_SIZE_9H = 3'h7;
    localparam logic [2:0] CHARACTER_SIZE_8 = 3'h3;
    localparam logic [3:0] NBITS_MIN = 4'h5;
    localparam logic [3:0] NBITS_8 = 4'h8;
    localparam logic [3:0] NBITS_9 = 4'h9;
    localparam logic [1:0] MODE_LIN = 2'h3;
    localparam logic [1:0] LIN_PID = 2'h1;
    localparam logic [1:0] LIN_RESP = 2'h2;
    localparam logic [7:0] CFG_RST = 8'h03;
    localparam logic [7:0] BAUD_RST = 8'h0F;
    localparam logic [1:0] RXQ_DEPTH = 2'h2;
    localparam logic [3:0] TX_OVERHEAD = 4'h2;
    localparam int IRQ_RXC = 0;
    localparam int IRQ_TXE = 1;
    localparam int IRQ_OVF = 2;
    localparam int IRQ_FE = 3;
    localparam int IRQ_W = 4;

    // layout matches the configuration register
    typedef struct packed {
        logic spi_host;
        logic [1:0] rx_mode;
        logic par_en;
        logic par_odd;
        logic [2:0] character_size;
    } ubr_cfg_t;

    typedef struct packed {
        logic [8:0] data;
        logic fe;
        logic pe;
    } ubr_frame_t;

    function automatic logic [3:0] ubr_nbits(input logic [2:0] cs);
        if (cs >= CHARACTER_SIZE_9L) begin
            return NBITS_9;
        end else if (cs > CHARACTER_SIZE_8) begin
            return NBITS_8;
        end
        return NBITS_MIN + {1'b0, cs};
    endfunction

    function automatic logic [8:0] ubr_mask(input logic [8:0] d, input logic [3:0] n);
        return d & ~(9'h1FF << n);
    endfunction
endpackage

// ==== ubr_rx.sv ====
// serial receiver with one held frame in the frame register, apart from the shift register
`timescale 1ns/100ps
`default_nettype none
module ubr_rx (
    input wire logic mclk,
    input wire logic reset,
    input wire logic rxd,
    input wire ubr_pkg::ubr_cfg_t cfg,
    input wire logic [7:0] baud,
    input wire logic take,
    output logic start_seen,
    output logic held,
    output var ubr_pkg::ubr_frame_t frame
);
    import ubr_pkg::*;

    typedef enum logic [3:0] {
        RX_IDLE = 4'h1,
        RX_START = 4'h2,
        RX_BITS = 4'h4,
        RX_STOP = 4'h8
    } ubr_rx_state_t;

    ubr_rx_state_t st_q;
    logic [1:0] sync_q;
    logic [7:0] cnt_q;
    logic [3:0] bit_q;
    logic [9:0] sh_q;

    wire logic rx_in = sync_q[1];
    wire logic tick = cnt_q == 8'h00;
    wire logic [3:0] nbits = ubr_nbits(cfg.character_size);
    wire logic [3:0] last = nbits + {3'h0, cfg.par_en} - 4'h1;
    wire logic [8:0] dmask = ubr_mask(sh_q[8:0], nbits);
    wire logic pbit = sh_q[nbits];
    wire logic parity_error_flag = cfg.par_en & (^dmask ^ pbit ^ cfg.par_odd);

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            sync_q <= 2'b11;
            st_q <= RX_IDLE;
            cnt_q <= 8'h00;
            bit_q <= 4'h0;
            sh_q <= 10'h000;
            held <= 1'b0;
            frame <= '0;
            start_seen <= 1'b0;
        end else begin
            sync_q <= {sync_q[0], rxd};
            start_seen <= 1'b0;
            cnt_q <= tick ? baud : cnt_q - 8'h01;
            if (take) begin
                held <= 1'b0;
            end
            case (st_q)
                RX_IDLE: if (!rx_in) begin
                    st_q <= RX_START;
                    cnt_q <= baud >> 1;
                    start_seen <= 1'b1;
                end
                RX_START: if (tick) begin
                    st_q <= rx_in ? RX_IDLE : RX_BITS;
                    bit_q <= 4'h0;
                    sh_q <= 10'h000;
                end
                RX_BITS: if (tick) begin
                    sh_q[bit_q] <= rx_in;
                    bit_q <= bit_q + 4'h1;
                    if (bit_q == last) begin
                        st_q <= RX_STOP;
                    end
                end
                RX_STOP: if (tick) begin
                    frame <= '{data: dmask, fe: !rx_in, pe: parity_error_flag};
                    held <= 1'b1;
                    st_q <= RX_IDLE;
                end
                default: st_q <= RX_IDLE;
            endcase
        end
    end

    property p_stop_fe;
        @(posedge mclk) disable iff (reset)
        (st_q == RX_STOP && tick) |=> (held && frame.fe == !$past(rx_in));
    endproperty
    a_stop_fe: assert property (p_stop_fe) else $error("frame error not from stop bit");
endmodule // ubr_rx
`default_nettype wire

// ==== ubr_top.sv ====
// receive queue, transmit path and register file of the data buffer
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module ubr_top (
    input wire logic mclk,
    input wire logic reset,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rd_data,
    input wire logic rxd,
    output logic txd,
    output logic irq
);
    import ubr_pkg::*;

    ubr_cfg_t cfg_q;
    logic [7:0] baud_q;
    logic [IRQ_W-1:0] irq_stat_q;
    logic [IRQ_W-1:0] irq_mask_q;
    logic [7:0] rdata_q;
    logic irq_q;

    ubr_frame_t rxq_q [RXQ_DEPTH];
    logic rxq_wp_q;
    logic rxq_rp_q;
    logic [1:0] rxq_cnt_q;
    logic ovf_q;
    logic [1:0] lin_pos_q;

    logic [7:0] txl_q;
    logic txh_q;
    logic [8:0] txb_q;
    logic txb_vld_q;
    logic [11:0] tsh_q;
    logic [3:0] tleft_q;
    logic [7:0] tcnt_q;
    logic txd_q;

    wire logic rx_start;
    wire logic rx_held;
    wire logic rxq_push;
    ubr_frame_t rx_frame;

    ubr_rx u_rx (
        .mclk(mclk),
        .reset(reset),
        .rxd(rxd),
        .cfg(cfg_q),
        .baud(baud_q),
        .take(rxq_push),
        .start_seen(rx_start),
        .held(rx_held),
        .frame(rx_frame)
    );

    // bus decode
    wire logic rd_low = rd && addr == ADDR_RX_LOW;
    wire logic rd_high = rd && addr == ADDR_RX_HIGH;
    wire logic rd_irq = rd && addr == ADDR_IRQ_STAT;
    wire logic wr_low = wr && addr == ADDR_TX_LOW;
    wire logic wr_high = wr && addr == ADDR_TX_HIGH;
    wire logic wr_cfg = wr && addr == ADDR_CFG;
    wire logic wr_baud = wr && addr == ADDR_BAUD;
    wire logic wr_mask = wr && addr == ADDR_IRQ_MASK;
    wire logic is_9l = cfg_q.character_size == CHARACTER_SIZE_9L;
    wire logic spi = cfg_q.spi_host;
    wire logic lin = cfg_q.rx_mode == MODE_LIN;

    // receive queue
    wire logic rxq_nempty = rxq_cnt_q != 2'h0;
    wire logic rxq_full = rxq_cnt_q == RXQ_DEPTH;
    wire logic rxq_pop = rxq_nempty && (is_9l ? rd_high : rd_low);
    assign rxq_push = rx_held && (!rxq_full || rxq_pop);
    wire logic ovf_set = rx_start && rxq_full && rx_held && !spi;
    wire logic rd_data_reg = rd_low || rd_high;
    wire ubr_frame_t head = rxq_q[rxq_rp_q];

    // lin field tracking: break, sync, identifier, then response
    wire logic lin_break = rx_frame.fe && rx_frame.data == 9'h000;
    wire logic [1:0] lin_pos_d = lin_break ? 2'h0 :
                                 (lin_pos_q == LIN_RESP) ? LIN_RESP :
                                 lin_pos_q + 2'h1;
    wire logic lin_resp = lin_pos_q == LIN_RESP;
    wire logic push_d8 = lin ? lin_resp : rx_frame.data[8];
    wire ubr_frame_t push_frame = '{
        data: {push_d8, rx_frame.data[7:0]},
        fe: rx_frame.fe,
        pe: rx_frame.pe
    };

    wire logic [1:0] rxq_cnt_d = rxq_cnt_q + {1'b0, rxq_push} - {1'b0, rxq_pop};

    // high byte view; errors hidden in spi host mode
    wire logic [7:0] rx_high_view = {
        rxq_nempty,
        ovf_q && !spi,
        3'h0,
        head.fe && !spi,
        head.pe && !spi,
        head.data[8]
    };

    // transmit path
    wire logic tx_idle = tleft_q == 4'h0;
    wire logic tx_load = txb_vld_q && tx_idle;
    wire logic tx_commit = !txb_vld_q && (is_9l ? wr_high : wr_low);
    wire logic [8:0] tx_char = is_9l ? {wdata[0], txl_q} : {txh_q, wdata};
    wire logic [3:0] tx_nbits = ubr_nbits(cfg_q.character_size);
    wire logic tx_tick = tcnt_q == 8'h00;

    function automatic logic [11:0] tx_frame(input logic [8:0] d, input ubr_cfg_t c);
        logic [3:0] n;
        logic [8:0] m;
        logic [11:0] v;
        n = ubr_nbits(c.character_size);
        m = ubr_mask(d, n);
        v = (12'hFFF << (n + 4'h1)) | {2'b00, m, 1'b0};
        if (c.par_en) begin
            v[n + 4'h1] = ^m ^ c.par_odd;
        end
        return v;
    endfunction

    wire logic [11:0] tx_vec = tx_frame(txb_q, cfg_q);
    wire logic [3:0] tx_len = tx_nbits + {3'h0, cfg_q.par_en} + TX_OVERHEAD;

    // interrupt status, read clears, set wins
    wire logic [IRQ_W-1:0] irq_ev = {
        rxq_push && rx_frame.fe && !spi,
        ovf_set,
        tx_load,
        rxq_push
    };
    wire logic [IRQ_W-1:0] irq_stat_d = (rd_irq ? '0 : irq_stat_q) | irq_ev;
    wire logic [IRQ_W-1:0] irq_mask_d = wr_mask ? wdata[IRQ_W-1:0] : irq_mask_q;
    wire logic [7:0] irq_view = {!txb_vld_q, 3'h0, irq_stat_q};

    wire logic [7:0] rd_mux =
        (addr == ADDR_RX_LOW) ? head.data[7:0] :
        (addr == ADDR_RX_HIGH) ? rx_high_view :
        (addr == ADDR_CFG) ? cfg_q :
        (addr == ADDR_BAUD) ? baud_q :
        (addr == ADDR_IRQ_STAT) ? irq_view :
        (addr == ADDR_IRQ_MASK) ? {4'h0, irq_mask_q} :
        8'h00;

    // register file
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            cfg_q <= CFG_RST;
            baud_q <= BAUD_RST;
            irq_stat_q <= '0;
            irq_mask_q <= '0;
            rdata_q <= 8'h00;
            irq_q <= 1'b0;
        end else begin
            if (wr_cfg) begin
                cfg_q <= wdata;
            end
            if (wr_baud) begin
                baud_q <= wdata;
            end
            irq_stat_q <= irq_stat_d;
            irq_mask_q <= irq_mask_d;
            rdata_q <= rd ? rd_mux : 8'h00;
            irq_q <= |(irq_stat_d & irq_mask_d);
        end
    end

    // receive queue storage
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            rxq_q[0] <= '0;
            rxq_q[1] <= '0;
            rxq_wp_q <= 1'b0;
            rxq_rp_q <= 1'b0;
            rxq_cnt_q <= 2'h0;
            lin_pos_q <= 2'h0;
        end else begin
            if (rxq_push) begin
                rxq_q[rxq_wp_q] <= push_frame;
                rxq_wp_q <= !rxq_wp_q;
                lin_pos_q <= lin_pos_d;
            end
            if (rxq_pop) begin
                rxq_rp_q <= !rxq_rp_q;
            end
            rxq_cnt_q <= rxq_cnt_d;
        end
    end

    // overflow: set beats the clearing read
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            ovf_q <= 1'b0;
        end else begin
            ovf_q <= ovf_set || (ovf_q && !rd_data_reg);
        end
    end

    // transmit holding and buffer
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            txl_q <= 8'h00;
            txh_q <= 1'b0;
            txb_q <= 9'h000;
            txb_vld_q <= 1'b0;
        end else begin
            if (wr_low) begin
                txl_q <= wdata;
            end
            if (wr_high) begin
                txh_q <= wdata[0];
            end
            if (tx_commit) begin
                txb_q <= tx_char;
                txb_vld_q <= 1'b1;
            end else if (tx_load) begin
                txb_vld_q <= 1'b0;
            end
        end
    end

    // transmit shifter, idles high
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            tsh_q <= 12'hFFF;
            tleft_q <= 4'h0;
            tcnt_q <= 8'h00;
            txd_q <= 1'b1;
        end else if (tx_load) begin
            tsh_q <= {1'b1, tx_vec[11:1]};
            txd_q <= tx_vec[0];
            tleft_q <= tx_len;
            tcnt_q <= baud_q;
        end else if (!tx_idle && tx_tick) begin
            tsh_q <= {1'b1, tsh_q[11:1]};
            txd_q <= tsh_q[0];
            tleft_q <= tleft_q - 4'h1;
            tcnt_q <= baud_q;
        end else if (!tx_idle) begin
            tcnt_q <= tcnt_q - 8'h01;
        end
    end

    assign rd_data = rdata_q;
    assign txd = txd_q;
    assign irq = irq_q;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);

    property p_rxc_flag;
        rd_high |=> rdata_q[7] == $past(rxq_nempty);
    endproperty
    a_rxc_flag: assert property (p_rxc_flag) else $error("receive complete flag wrong");

    property p_pop;
        rxq_pop |=> rxq_cnt_q == $past(rxq_cnt_q) - 2'h1 + {1'b0, $past(rxq_push)};
    endproperty
    a_pop: assert property (p_pop) else $error("queue did not advance");

    property p_no_pop;
        (rd && addr == (is_9l ? ADDR_RX_LOW : ADDR_RX_HIGH) && !rxq_push) |=> $stable(rxq_cnt_q);
    endproperty
    a_no_pop: assert property (p_no_pop) else $error("wrong byte advanced queue");

    property p_oldest;
        rd_low |=> rdata_q == $past(rxq_q[rxq_rp_q].data[7:0]);
    endproperty
    a_oldest: assert property (p_oldest) else $error("low byte not oldest frame");

    property p_ovf_set;
        ovf_set |=> ovf_q;
    endproperty
    a_ovf_set: assert property (p_ovf_set) else $error("overflow not flagged");

    property p_ovf_clr;
        (rd_data_reg && !ovf_set) |=> !ovf_q;
    endproperty
    a_ovf_clr: assert property (p_ovf_clr) else $error("overflow not cleared by read");

    property p_spi_quiet;
        (rd_high && spi) |=> rdata_q[6:1] == 6'h00;
    endproperty
    a_spi_quiet: assert property (p_spi_quiet) else $error("error flag seen in spi host");

    property p_commit;
        tx_commit |=> txb_vld_q && txb_q == $past(tx_char);
    endproperty
    a_commit: assert property (p_commit) else $error("transmit char not committed");

    property p_no_commit;
        (wr && addr == (is_9l ? ADDR_TX_LOW : ADDR_TX_HIGH) && !txb_vld_q) |=> !txb_vld_q;
    endproperty
    a_no_commit: assert property (p_no_commit) else $error("wrong byte committed");

    sequence s_load;
        tx_load ##1 !txd_q;
    endsequence
    property p_start_bit;
        tx_load |-> s_load ##0 !txb_vld_q;
    endproperty
    a_start_bit: assert property (p_start_bit) else $error("start bit not driven on load");
endmodule // ubr_top
`default_nettype wire

// ==== ubr_peer.sv ====
// line-side peer: drives frames on rxd and decodes frames seen on txd
`timescale 1ns/100ps
`default_nettype none
module ubr_peer #(
    parameter int BIT_CYC = 4
) (
    input wire logic mclk,
    input wire logic txd,
    output logic rxd
);
    int nb = 8;
    logic pen = 1'b0;
    logic podd = 1'b0;
    logic [8:0] got_q;
    logic got_par;
    logic got_stop;
    int got_n = 0;
    initial rxd = 1'b1;
    task automatic put(input logic b, input int n);
        @(posedge mclk);
        rxd <= b;
        repeat (n - 1) @(posedge mclk);
    endtask
    // a low stop is cut short so it is not taken for a new start
    task automatic send(input logic [8:0] d, input logic stop, input logic bad);
        put(1'b0, BIT_CYC);
        for (int i = 0; i < nb; i++) put(d[i], BIT_CYC);
        if (pen) put(^(d & ~(9'h1FF << nb)) ^ podd ^ bad, BIT_CYC);
        put(stop, stop ? BIT_CYC : BIT_CYC - 1);
        put(1'b1, 3 * BIT_CYC);
    endtask
    always begin
        @(negedge txd);
        got_q = 9'h000;
        repeat (BIT_CYC / 2) @(posedge mclk);
        for (int i = 0; i < nb; i++) begin
            repeat (BIT_CYC) @(posedge mclk);
            got_q[i] = txd;
        end
        if (pen) begin
            repeat (BIT_CYC) @(posedge mclk);
            got_par = txd;
        end
        repeat (BIT_CYC) @(posedge mclk);
        got_stop = txd;
        got_n++;
    end
endmodule // ubr_peer
`default_nettype wire

// ==== ubr_top_test.sv ====
// self-checking bench for the data buffer registers
`timescale 1ns/100ps
`default_nettype none
module ubr_top_test;
    import ubr_pkg::*;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rd_data;
    logic rxd;
    logic txd;
    logic irq;
    int mismatches = 0;
    int n_checks = 0;
    int cyc = 0;
    int seed = 90;
    logic [7:0] cfgs [4] = '{8'h03, 8'h16, 8'h1F, 8'h98};
    always #2 mclk = ~mclk;
    ubr_top u_ubr_top (.mclk(mclk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rd_data(rd_data), .rxd(rxd), .txd(txd), .irq(irq));
    ubr_peer #(.BIT_CYC(4)) u_ubr_peer (.mclk(mclk), .txd(txd), .rxd(rxd));
    task automatic wrap_up();
        if (mismatches == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 30000) begin
            mismatches++;
            wrap_up();
        end
    end
    task automatic chk(input string what, input logic [8:0] seen, input logic [8:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge mclk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
        @(posedge mclk);
        rd <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rd <= 1'b0;
        #1 d = rd_data;
    endtask
    task automatic rd_frame(input logic nl, output logic [7:0] h, output logic [7:0] l);
        if (nl) begin
            rd_reg(ADDR_RX_LOW, l);
            rd_reg(ADDR_RX_HIGH, h);
        end else begin
            rd_reg(ADDR_RX_HIGH, h);
            rd_reg(ADDR_RX_LOW, l);
        end
    endtask
    function automatic int nb_of(input logic [2:0] cs);
        return cs >= 3'h6 ? 9 : cs > 3'h3 ? 8 : 5 + cs;
    endfunction
    initial begin
        logic [8:0] d [4];
        logic [8:0] m;
        logic [7:0] h;
        logic [7:0] l;
        logic [2:0] cs;
        logic nl;
        logic spi;
        int n0;
        repeat (8) @(posedge mclk);
        reset <= 1'b0;
        chk("txd idle", txd, 1'b1);
        chk("irq idle", irq, 1'b0);
        wr_reg(ADDR_RX_LOW, 8'hA5);
        rd_reg(ADDR_RX_LOW, h);
        chk("rx low reset", h, 8'h00);
        rd_reg(ADDR_RX_HIGH, h);
        chk("rx high reset", h, 8'h00);
        rd_reg(4'h9, h);
        chk("unmapped", h, 8'h00);
        wr_reg(ADDR_BAUD, 8'h03);
        for (int k = 0; k < 4; k++) begin
            cs = cfgs[k][2:0];
            spi = cfgs[k][7];
            nl = (cs == CHARACTER_SIZE_9L);
            u_ubr_peer.nb = nb_of(cs);
            u_ubr_peer.pen = cfgs[k][4];
            u_ubr_peer.podd = cfgs[k][3];
            wr_reg(ADDR_CFG, cfgs[k]);
            // third frame is held, fourth start overflows and replaces it
            for (int i = 0; i < 4; i++) begin
                d[i] = $random(seed) & ~(9'h1FF << nb_of(cs));
                u_ubr_peer.send(d[i], i != 1, i == 3);
            end
            chk("irq", irq, k > 0);
            rd_reg(ADDR_IRQ_STAT, h);
            if (k == 0) begin
                chk("irq status", h, 8'h8D);
                wr_reg(ADDR_IRQ_MASK, 8'h01);
            end
            chk("irq cleared", irq, 1'b0);
            for (int i = 0; i < 3; i++) begin
                m = d[i + (i == 2)];
                rd_frame(nl, h, l);
                chk("rx low", l, m[7:0]);
                chk("rx high", h, {1'b1, i == 0 && !spi && !nl, 3'b000, i == 1 && !spi,
                    i == 2 && !spi && cfgs[k][4], m[8]});
            end
            rd_reg(ADDR_RX_HIGH, h);
            chk("rx empty", h[7], 1'b0);
            m = $random(seed) & ~(9'h1FF << nb_of(cs));
            n0 = u_ubr_peer.got_n;
            if (nl) begin
                wr_reg(ADDR_TX_LOW, m[7:0]);
            end else begin
                wr_reg(ADDR_TX_HIGH, {7'h00, m[8]});
            end
            repeat (8) @(posedge mclk);
            chk("tx not committed", txd, 1'b1);
            if (nl) begin
                wr_reg(ADDR_TX_HIGH, {7'h00, m[8]});
            end else begin
                wr_reg(ADDR_TX_LOW, m[7:0]);
            end
            for (int t = 0; t < 500 && u_ubr_peer.got_n == n0; t++) @(posedge mclk);
            chk("tx data", u_ubr_peer.got_q, m);
            chk("tx stop", u_ubr_peer.got_stop, 1'b1);
            if (cfgs[k][4]) chk("tx parity", u_ubr_peer.got_par, ^m ^ cfgs[k][3]);
            repeat (6) @(posedge mclk);
        end
        u_ubr_peer.nb = 8;
        u_ubr_peer.pen = 1'b0;
        wr_reg(ADDR_CFG, 8'h63);
        u_ubr_peer.send(9'h000, 1'b0, 1'b0);
        u_ubr_peer.send(9'h055, 1'b1, 1'b0);
        rd_frame(1'b0, h, l);
        rd_frame(1'b0, h, l);
        chk("lin sync", h[0], 1'b0);
        u_ubr_peer.send(9'h0A3, 1'b1, 1'b0);
        u_ubr_peer.send(9'h05C, 1'b1, 1'b0);
        rd_frame(1'b0, h, l);
        chk("lin id", {h[0], l}, 9'h0A3);
        rd_frame(1'b0, h, l);
        chk("lin resp", {h[0], l}, 9'h15C);
        wrap_up();
    end
endmodule // ubr_top_test
`default_nettype wire
